// >>> verilog/aors_pkg.sv
// Constants, field positions and coding helpers for the output refresh scanner.
// Assumes a 200 MHz core clock and a 16-bit host data path.
package aors_pkg;
   localparam int NUM_CH = 8;
   localparam int CH_W = 3;
   localparam int CODE_W = 12;
   localparam int WORD_W = 16;
   localparam int ADDR_W = 5;

   // Byte addresses: control/status at 0x00-0x0E, channel codes at 0x10-0x1E
   localparam int REGION_BIT = 4;
   localparam int IDX_LSB = 1;
   localparam logic [ADDR_W-1:0] CTRL_BASE = 5'h00;
   localparam logic [ADDR_W-1:0] CODE_BASE = 5'h10;

   // Control and status word fields
   localparam int LED_OFF_BIT = 11;
   localparam int TWOS_BIT = 10;
   localparam int VOUT_BIT = 9;
   localparam int SCAN_BIT = 7;
   localparam logic [3:0] STAT_FIXED_HI = 4'hF;
   localparam logic [3:0] STAT_FIXED_LO = 4'h0;
   localparam logic STAT_RSVD = 1'h0;
   localparam logic CTRL_RST = 1'h0;
   localparam logic [3:0] CODE_PAD = 4'h0;

   localparam int CODE_SIGN_BIT = 11;
   localparam logic [CH_W-1:0] LAST_CH = 3'h7;
   localparam logic [CH_W-1:0] FIRST_CH = 3'h0;

   // Worst-case update time from a code write to the converter
   localparam int UPDATE_LIMIT_US = 792;
   localparam int CLK_PERIOD_PS = 5000;
   // One spare slot of margin: a write just missing its slot waits a full round
   localparam int SLOT_CYCLES_DEF =
      (UPDATE_LIMIT_US * 1000000 / CLK_PERIOD_PS) / (NUM_CH + 1);

   function automatic logic is_code_addr(input logic [ADDR_W-1:0] a);
      return a[REGION_BIT];
   endfunction

   function automatic logic [CH_W-1:0] addr_ch(input logic [ADDR_W-1:0] a);
      return a[IDX_LSB +: CH_W];
   endfunction

   // Two's complement is offset binary with the sign bit turned over
   function automatic logic [CODE_W-1:0] dac_coded(input logic [CODE_W-1:0] c,
                                                  input logic twos);
      logic [CODE_W-1:0] r;
      r = c;
      r[CODE_SIGN_BIT] = c[CODE_SIGN_BIT] ^ twos;
      return r;
   endfunction
endpackage

// >>> verilog/aors_store_if.sv
// Link between the scanner top and its code store.
// Assumes one clock; read data on both ports is combinational.
`timescale 1ns/1ps
`default_nettype none
interface aors_store_if;
   import aors_pkg::*;
   logic host_we;
   logic [CH_W-1:0] host_idx;
   logic [CODE_W-1:0] host_wdata;
   logic [CODE_W-1:0] host_rdata;
   logic [CH_W-1:0] scan_idx;
   logic [CODE_W-1:0] scan_rdata;
   modport owner (output host_we, host_idx, host_wdata, scan_idx,
                  input host_rdata, scan_rdata);
   modport store (input host_we, host_idx, host_wdata, scan_idx,
                  output host_rdata, scan_rdata);
endinterface
`default_nettype wire

// >>> verilog/aors_code_store.sv
// Eight-word channel code store with a host port and a scanner read port.
// Assumes the owner drives one write per cycle at most.
`timescale 1ns/1ps
`default_nettype none
module aors_code_store
   import aors_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Ports
   aors_store_if.store sif
);
   // No reset: contents are undefined until software loads them
   logic [CODE_W-1:0] mem [NUM_CH];

   always_ff @(posedge core_clk) begin
      if (sif.host_we) begin
         mem[sif.host_idx] <= sif.host_wdata;
      end
   end

   assign sif.host_rdata = mem[sif.host_idx];
   assign sif.scan_rdata = mem[sif.scan_idx];
endmodule
`default_nettype wire

// >>> verilog/aors_slot_timer.sv
// Refresh slot divider and channel counter.
// Assumes scan_en is a registered control level.
`timescale 1ns/1ps
`default_nettype none
module aors_slot_timer
   import aors_pkg::*;
#(
   parameter int SLOT_CYCLES = SLOT_CYCLES_DEF
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Control
   input wire logic scan_en,
   // Slot outputs
   output logic slot_tick,
   output logic [CH_W-1:0] refresh_channel_index
);
   localparam int CNT_W = $clog2(SLOT_CYCLES);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SLOT_CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   logic [CNT_W-1:0] div_cnt;

   assign slot_tick = scan_en && (div_cnt == CNT_LAST);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         div_cnt <= CNT_ZERO;
      end else if (!scan_en || slot_tick) begin
         div_cnt <= CNT_ZERO;
      end else begin
         div_cnt <= div_cnt + CNT_ONE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         refresh_channel_index <= FIRST_CH;
      end else if (slot_tick) begin
         refresh_channel_index <= (refresh_channel_index == LAST_CH) ? FIRST_CH
                                  : refresh_channel_index + CH_W'(1);
      end
   end
endmodule
`default_nettype wire

// >>> verilog/aors_scanner.sv
// Top of the analog output refresh scanner: host port, control word,
// code store and converter feed.
// Assumes host strobes are one-cycle pulses synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - Eight channels appear as eight consecutive code words.
// - Code words are writable and read back the stored code.
// - Code is right-aligned in the low twelve bits.
// - Top four written bits are dropped and read back as zero.
// - A new code reaches its converter within 792 us when scanning.
// - Straight binary passes codes unchanged, 000 min, FFF max.
// - Two's complement maps 800 to minimum, 7FF to maximum.
// - Voltage connect bit 9 set closes the output switches.
// - Voltage connect bit clear holds the switches open.
// - Refresh runs only while scan bit 7 is set.
// - Bit 10 selects coding by inverting code bit 11.
// - Reset clears control bits: LED lit, outputs open, scan off.
// - Status low three bits show the refresh channel counter.
module aors_scanner
   import aors_pkg::*;
#(
   parameter int SLOT_CYCLES = SLOT_CYCLES_DEF
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Host register port
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [ADDR_W-1:0] host_addr,
   input wire logic [WORD_W-1:0] host_wdata,
   output logic [WORD_W-1:0] host_rdata,
   output logic host_rack,
   // Converter feed
   output logic [CODE_W-1:0] dac_code,
   output logic [CH_W-1:0] dac_channel,
   output logic dac_load,
   // Output stage control
   output logic vout_connect,
   output logic fail_led_on
);
   aors_store_if sif ();

   logic led_off;
   logic twos_comp;
   logic vout_en;
   logic scan_en;
   logic slot_tick;
   logic [CH_W-1:0] refresh_channel_index;
   logic ctrl_wr;
   logic [WORD_W-1:0] control_status_word;

   aors_code_store u_store (
      .core_clk(core_clk),
      .sif(sif.store)
   );

   aors_slot_timer #(
      .SLOT_CYCLES(SLOT_CYCLES)
   ) u_timer (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .scan_en(scan_en),
      .slot_tick(slot_tick),
      .refresh_channel_index(refresh_channel_index)
   );

   assign sif.host_idx = addr_ch(host_addr);
   assign sif.host_we = host_wr && is_code_addr(host_addr);
   assign sif.host_wdata = host_wdata[CODE_W-1:0];
   assign sif.scan_idx = refresh_channel_index;
   assign ctrl_wr = host_wr && !is_code_addr(host_addr);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         led_off <= CTRL_RST;
         twos_comp <= CTRL_RST;
         vout_en <= CTRL_RST;
         scan_en <= CTRL_RST;
      end else if (ctrl_wr) begin
         led_off <= host_wdata[LED_OFF_BIT];
         twos_comp <= host_wdata[TWOS_BIT];
         vout_en <= host_wdata[VOUT_BIT];
         scan_en <= host_wdata[SCAN_BIT];
      end
   end

   assign vout_connect = vout_en;
   assign fail_led_on = !led_off;

   assign control_status_word = {STAT_FIXED_HI, led_off, twos_comp, vout_en,
                                 STAT_RSVD, scan_en, STAT_FIXED_LO,
                                 refresh_channel_index};

   // Read data is registered; a write in the same cycle takes priority
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         host_rdata <= '0;
         host_rack <= 1'h0;
      end else begin
         host_rack <= host_rd && !host_wr;
         if (host_rd && !host_wr) begin
            host_rdata <= is_code_addr(host_addr) ? {CODE_PAD, sif.host_rdata}
                          : control_status_word;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         dac_code <= '0;
         dac_channel <= FIRST_CH;
         dac_load <= 1'h0;
      end else begin
         dac_load <= slot_tick;
         if (slot_tick) begin
            dac_code <= dac_coded(sif.scan_rdata, twos_comp);
            dac_channel <= refresh_channel_index;
         end
      end
   end

   // Helper: cycles since the last converter load while scanning
   localparam int GAP_W = $clog2(SLOT_CYCLES) + 2;
   logic [GAP_W-1:0] gap_cnt;
   always_ff @(posedge core_clk) begin
      if (!rst_n || !scan_en || dac_load) begin
         gap_cnt <= '0;
      end else if (gap_cnt != '1) begin
         gap_cnt <= gap_cnt + GAP_W'(1);
      end
   end

   sequence s_code_wr;
      host_wr && is_code_addr(host_addr);
   endsequence

   sequence s_same_rd;
      host_rd && !host_wr && is_code_addr(host_addr)
         && addr_ch(host_addr) == $past(addr_ch(host_addr));
   endsequence

   sequence s_ctrl_wr_bit(int b, logic v);
      ctrl_wr && host_wdata[b] == v;
   endsequence

   property p_readback;
      @(posedge core_clk) disable iff (!rst_n)
         s_code_wr ##1 s_same_rd |=>
            host_rack && host_rdata == {CODE_PAD, $past(host_wdata[CODE_W-1:0], 2)};
   endproperty
   a_readback: assert property (p_readback)
      else $error("code word did not read back as written");

   property p_top_zero;
      @(posedge core_clk) disable iff (!rst_n)
         host_rd && !host_wr && is_code_addr(host_addr) |=>
            host_rdata[WORD_W-1:CODE_W] == CODE_PAD;
   endproperty
   a_top_zero: assert property (p_top_zero)
      else $error("upper code bits read back nonzero");

   property p_vout_on;
      @(posedge core_clk) disable iff (!rst_n)
         s_ctrl_wr_bit(VOUT_BIT, 1'h1) |=> vout_connect;
   endproperty
   a_vout_on: assert property (p_vout_on)
      else $error("voltage switches not closed after connect write");

   property p_vout_off;
      @(posedge core_clk) disable iff (!rst_n)
         s_ctrl_wr_bit(VOUT_BIT, 1'h0) |=> !vout_connect;
   endproperty
   a_vout_off: assert property (p_vout_off)
      else $error("voltage switches not opened after disconnect write");

   property p_no_scan;
      @(posedge core_clk) disable iff (!rst_n)
         !scan_en |=> !dac_load;
   endproperty
   a_no_scan: assert property (p_no_scan)
      else $error("converter loaded while scanning is off");

   property p_reset_clear;
      @(posedge core_clk)
         !rst_n |=> !vout_connect && fail_led_on && !scan_en && !twos_comp;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("control bits not cleared by reset");

   property p_status_cnt;
      @(posedge core_clk) disable iff (!rst_n)
         host_rd && !host_wr && !is_code_addr(host_addr) |=>
            host_rdata[CH_W-1:0] == $past(refresh_channel_index)
            && host_rdata[WORD_W-1:WORD_W-4] == STAT_FIXED_HI;
   endproperty
   a_status_cnt: assert property (p_status_cnt)
      else $error("status word does not show the channel counter");

   property p_wrap;
      @(posedge core_clk) disable iff (!rst_n)
         slot_tick && refresh_channel_index == LAST_CH |=>
            refresh_channel_index == FIRST_CH ##0 dac_channel == LAST_CH;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("channel counter did not wrap after the last channel");

   property p_twos;
      @(posedge core_clk) disable iff (!rst_n)
         slot_tick && twos_comp |=>
            dac_code[CODE_SIGN_BIT] != $past(sif.scan_rdata[CODE_SIGN_BIT])
            && dac_code[CODE_SIGN_BIT-1:0] == $past(sif.scan_rdata[CODE_SIGN_BIT-1:0]);
   endproperty
   a_twos: assert property (p_twos)
      else $error("two's complement code not converted by sign inversion");

   property p_straight;
      @(posedge core_clk) disable iff (!rst_n)
         slot_tick && !twos_comp |=> dac_load && dac_code == $past(sif.scan_rdata);
   endproperty
   a_straight: assert property (p_straight)
      else $error("straight binary code altered on its way to the converter");

   property p_gap;
      @(posedge core_clk) disable iff (!rst_n)
         scan_en |-> gap_cnt <= GAP_W'(SLOT_CYCLES);
   endproperty
   a_gap: assert property (p_gap)
      else $error("refresh slot spacing exceeded");

   // Read answer comes exactly one cycle after an accepted read
   property p_rack;
      @(posedge core_clk) disable iff (!rst_n)
         host_rd && !host_wr |=> host_rack;
   endproperty
   a_rack: assert property (p_rack)
      else $error("read strobe not answered on the next cycle");

   property p_wr_no_rack;
      @(posedge core_clk) disable iff (!rst_n)
         host_wr |=> !host_rack;
   endproperty
   a_wr_no_rack: assert property (p_wr_no_rack)
      else $error("read answered in a cycle owned by a write");

   property p_ctrl_take;
      @(posedge core_clk) disable iff (!rst_n)
         ctrl_wr |=> scan_en == $past(host_wdata[SCAN_BIT])
            && twos_comp == $past(host_wdata[TWOS_BIT])
            && fail_led_on == !$past(host_wdata[LED_OFF_BIT]);
   endproperty
   a_ctrl_take: assert property (p_ctrl_take)
      else $error("control write did not take scan, coding and lamp bits");

   property p_step;
      @(posedge core_clk) disable iff (!rst_n)
         slot_tick && refresh_channel_index != LAST_CH |=>
            refresh_channel_index == $past(refresh_channel_index) + CH_W'(1);
   endproperty
   a_step: assert property (p_step)
      else $error("channel counter did not step to the next channel");

   // Sampled reset in the antecedent keeps a mid-run reset from looking like a jump
   property p_idx_hold;
      @(posedge core_clk) disable iff (!rst_n)
         rst_n && !slot_tick |=> $stable(refresh_channel_index);
   endproperty
   a_idx_hold: assert property (p_idx_hold)
      else $error("channel counter moved outside a refresh slot");

   property p_load_ch;
      @(posedge core_clk) disable iff (!rst_n)
         slot_tick |=> dac_load && dac_channel == $past(refresh_channel_index);
   endproperty
   a_load_ch: assert property (p_load_ch)
      else $error("converter load does not carry the slot channel");

   property p_dac_hold;
      @(posedge core_clk) disable iff (!rst_n)
         rst_n && !slot_tick |=> $stable(dac_code) && $stable(dac_channel);
   endproperty
   a_dac_hold: assert property (p_dac_hold)
      else $error("converter feed changed outside a refresh slot");

   property p_status_fixed;
      @(posedge core_clk) disable iff (!rst_n)
         host_rd && !host_wr && !is_code_addr(host_addr) |=>
            host_rdata[SCAN_BIT-1:CH_W] == STAT_FIXED_LO
            && host_rdata[SCAN_BIT+1] == STAT_RSVD;
   endproperty
   a_status_fixed: assert property (p_status_fixed)
      else $error("fixed status bits read back wrong");
endmodule
`default_nettype wire

// >>> dv/aors_host_model.sv
// Host processor model driving the scanner's register port.
// Assumes one-cycle strobes and a read answer exactly one cycle later.
`timescale 1ns/1ps
`default_nettype none
module aors_host_model
   import aors_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Host register port
   output logic host_wr,
   output logic host_rd,
   output logic [ADDR_W-1:0] host_addr,
   output logic [WORD_W-1:0] host_wdata,
   input wire logic [WORD_W-1:0] host_rdata,
   input wire logic host_rack
);
   initial begin
      host_wr = 1'h0;
      host_rd = 1'h0;
      host_addr = 5'h1F;
      host_wdata = 16'hFFFF;
   end

   // Idle bus shows inverted values so stale data never passes for a request
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
      @(posedge core_clk);
      host_wr <= 1'h1;
      host_addr <= a;
      host_wdata <= d;
      @(posedge core_clk);
      host_wr <= 1'h0;
      host_addr <= ~a;
      host_wdata <= ~d;
   endtask

   // Write then read the same word on the very next cycle
   task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d,
                        output logic [WORD_W-1:0] q, output logic ok);
      @(posedge core_clk);
      host_wr <= 1'h1;
      host_addr <= a;
      host_wdata <= d;
      @(posedge core_clk);
      host_wr <= 1'h0;
      host_rd <= 1'h1;
      host_wdata <= ~d;
      @(posedge core_clk);
      host_rd <= 1'h0;
      host_addr <= ~a;
      @(posedge core_clk);
      ok = host_rack;
      q = host_rdata;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [WORD_W-1:0] d,
                     output logic ok);
      @(posedge core_clk);
      host_rd <= 1'h1;
      host_addr <= a;
      @(posedge core_clk);
      host_rd <= 1'h0;
      host_addr <= ~a;
      @(posedge core_clk);
      ok = host_rack;
      d = host_rdata;
   endtask
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the output refresh scanner.
// Assumes the host model drives the register port; short slots in sim.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
   $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module testbench
   import aors_pkg::*;
;
   localparam int SC = 16;
   logic core_clk;
   logic rst_n;
   logic host_wr, host_rd, host_rack, dac_load, vout_connect, fail_led_on;
   logic [ADDR_W-1:0] host_addr;
   logic [WORD_W-1:0] host_wdata, host_rdata;
   logic [CODE_W-1:0] dac_code;
   logic [CH_W-1:0] dac_channel, want_ch;
   logic [CODE_W-1:0] exp_code [NUM_CH];
   logic tw;
   logic [WORD_W-1:0] seq_rdata;
   logic seq_ok;
   int mismatches, total_checks, cyc, nld;

   aors_scanner #(.SLOT_CYCLES(SC)) aors_scanner_inst (.core_clk(core_clk), .rst_n(rst_n),
      .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
      .host_rdata(host_rdata), .host_rack(host_rack), .dac_code(dac_code),
      .dac_channel(dac_channel), .dac_load(dac_load), .vout_connect(vout_connect),
      .fail_led_on(fail_led_on));
   aors_host_model aors_host_model_inst (.core_clk(core_clk), .host_wr(host_wr),
      .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
      .host_rdata(host_rdata), .host_rack(host_rack));

   initial begin
      core_clk = 1'h0;
      forever #2.5 core_clk = ~core_clk;
   end

   always @(posedge core_clk) cyc <= cyc + 1;

   task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] e);
      logic [WORD_W-1:0] rv;
      logic rk;
      aors_host_model_inst.rd(a, rv, rk);
      `CHK(rk, 1'h1)
      `CHK(rv, e)
   endtask

   // Loads must come in channel order, one slot apart, with the coded store value
   task automatic scan_check(input int n);
      int prev;
      int w;
      prev = -1;
      for (int i = 0; i < n; i++) begin
         w = 0;
         do begin
            @(posedge core_clk);
            w++;
         end while (dac_load !== 1'h1 && w < 4 * SC);
         `CHK(dac_load, 1'h1)
         if (prev >= 0) `CHK(cyc - prev, SC)
         `CHK(dac_channel, want_ch)
         `CHK(dac_code, exp_code[want_ch] ^ {tw, 11'h0})
         prev = cyc;
         want_ch = want_ch + 3'h1;
      end
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge core_clk);
      mismatches++;
      results();
   end

   initial begin
      rst_n = 1'h0;
      tw = 1'h0;
      mismatches = 0;
      total_checks = 0;
      want_ch = FIRST_CH;
      exp_code = '{12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'h123, 12'hABC, 12'h001, 12'hFFE};
      repeat (12) @(posedge core_clk);
      rst_n <= 1'h1;
      @(posedge core_clk);
      #1;
      `CHK(vout_connect, 1'h0)
      `CHK(fail_led_on, 1'h1)
      chk_rd(5'h0E, 16'hF000);
      for (int i = 0; i < NUM_CH; i++) begin
         aors_host_model_inst.wr(CODE_BASE + 5'(2 * i), {4'(15 - i), exp_code[i]});
      end
      for (int i = 0; i < NUM_CH; i++) begin
         chk_rd(CODE_BASE + 5'(2 * i), {4'h0, exp_code[i]});
      end
      exp_code[5] = 12'h5A5;
      aors_host_model_inst.wr_rd(CODE_BASE + 5'h0A, 16'hC5A5, seq_rdata, seq_ok);
      `CHK(seq_ok, 1'h1)
      `CHK(seq_rdata, {4'h0, exp_code[5]})
      $display("test store done");
      aors_host_model_inst.wr(CTRL_BASE, 16'h0A80);
      #1;
      `CHK(vout_connect, 1'h1)
      `CHK(fail_led_on, 1'h0)
      scan_check(9);
      chk_rd(5'h04, 16'hFA80 | {13'h0, want_ch});
      exp_code[3] = 12'h3C3;
      aors_host_model_inst.wr(5'h16, 16'h73C3);
      scan_check(9);
      $display("test scan done");
      tw = 1'h1;
      aors_host_model_inst.wr(5'h08, 16'h0E80);
      scan_check(8);
      chk_rd(5'h0A, 16'hFE80 | {13'h0, want_ch});
      $display("test coding done");
      aors_host_model_inst.wr(CTRL_BASE, 16'h0200);
      nld = 0;
      for (int k = 0; k < 3 * SC; k++) begin
         @(posedge core_clk);
         if (dac_load === 1'h1) nld++;
      end
      `CHK(nld, 0)
      chk_rd(5'h0C, 16'hF200 | {13'h0, want_ch});
      `CHK(fail_led_on, 1'h1)
      aors_host_model_inst.wr(CTRL_BASE, 16'h0000);
      #1;
      `CHK(vout_connect, 1'h0)
      $display("test stop done");
      aors_host_model_inst.wr(CTRL_BASE, 16'h0A80);
      @(posedge core_clk);
      rst_n <= 1'h0;
      @(posedge core_clk);
      rst_n <= 1'h1;
      @(posedge core_clk);
      #1;
      `CHK(vout_connect, 1'h0)
      chk_rd(5'h00, 16'hF000);
      $display("test reset done");
      results();
   end
endmodule
`default_nettype wire
